// ==== rtl/pbs_host_ctl.sv ====
// Host end: APB register slave, serial status poller, mode sequencer.
// Assumes the device end shares CORE_CLK_I.
`timescale 1ns/1ps
`default_nettype none
module pbs_host_ctl
    import pbs_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    pbs_link_if.host LINK,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);
    typedef enum logic [1:0] {
        H_STOP,
        H_ANG,
        H_LIN
    } pbs_hstate_type;

    typedef struct packed {
        pbs_hstate_type hs;
        logic run;
        logic low_pwr;
        logic ext_pwm;
        logic [7:0] target;
        logic [5:0] bit_cnt;
        logic polling;
        logic phase;
        logic load;
        logic shift;
        logic [STAT_BITS-1:0] rx;
        logic [STAT_BITS-1:0] word;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pbs_host_state_type;

    pbs_host_state_type st_ff;
    pbs_host_state_type nxt_st;
    logic wr;
    logic done;
    logic wl;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        wr = PSEL_I && PENABLE_I && st_ff.pready && PWRITE_I;
        done = 1'b0;
        wl = 1'b0;
        // APB: answer prepared in setup, ready during access
        nxt_st.pready = PSEL_I && !PENABLE_I;
        nxt_st.pslverr = 1'b0;
        if (PSEL_I && !PENABLE_I) begin
            nxt_st.prdata = '0;
            unique case (PADDR_I)
                REG_CTRL: nxt_st.prdata = {29'h0, st_ff.ext_pwm, st_ff.low_pwr, st_ff.run};
                REG_TARGET: nxt_st.prdata = {24'h0, st_ff.target};
                REG_STATE: nxt_st.prdata = {30'h0, st_ff.hs};
                REG_STATWORD: nxt_st.prdata = st_ff.word;
                default: nxt_st.pslverr = 1'b1;
            endcase
            if (PWRITE_I && PADDR_I > REG_TARGET && PADDR_I <= REG_STATWORD) begin
                nxt_st.pslverr = 1'b1;
            end
        end
        if (wr && PADDR_I == REG_CTRL) begin
            nxt_st.run = PWDATA_I[0];
            nxt_st.low_pwr = PWDATA_I[1];
            nxt_st.ext_pwm = PWDATA_I[2];
        end
        if (wr && PADDR_I == REG_TARGET) begin
            nxt_st.target = PWDATA_I[7:0];
        end
        // Status poller: load, then sample one bit per two cycles
        nxt_st.load = 1'b0;
        nxt_st.shift = 1'b0;
        if (!st_ff.polling && !st_ff.load) begin
            nxt_st.load = 1'b1;
            nxt_st.polling = 1'b1;
            nxt_st.phase = 1'b0;
            nxt_st.bit_cnt = '0;
        end else if (st_ff.polling && !st_ff.load) begin
            nxt_st.phase = ~st_ff.phase;
            if (!st_ff.phase) begin
                nxt_st.rx = {st_ff.rx[STAT_BITS-2:0], LINK.serial_status_out};
                nxt_st.shift = 1'b1;
                if (st_ff.bit_cnt == STAT_LAST) begin
                    done = 1'b1;
                    nxt_st.polling = 1'b0;
                    nxt_st.shift = 1'b0;
                    nxt_st.word = {st_ff.rx[STAT_BITS-2:0], LINK.serial_status_out};
                end
                nxt_st.bit_cnt = st_ff.bit_cnt + 6'h01;
            end
        end
        wl = nxt_st.word[ST_WLOCK];
        // Mode sequencing; wide-lock moves on fresh status only
        unique case (st_ff.hs)
            H_STOP: if (st_ff.run) nxt_st.hs = H_ANG;
            H_ANG: begin
                if (!st_ff.run) begin
                    nxt_st.hs = H_STOP;
                end else if (done && wl) begin
                    nxt_st.hs = H_LIN;
                end
            end
            H_LIN: begin
                if (!st_ff.run) begin
                    nxt_st.hs = H_STOP;
                end else if (done && !wl) begin
                    nxt_st.hs = H_ANG;
                end
            end
            default: nxt_st.hs = H_STOP;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            st_ff <= '0;
            st_ff.hs <= H_STOP;
            st_ff.target <= TARGET_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign LINK.mode = (st_ff.hs == H_ANG) ? MODE_WIDE_ANG : (st_ff.hs == H_LIN) ? MODE_WIDE_LIN : MODE_NARROW;
    assign LINK.spin_run = (st_ff.hs != H_STOP);
    assign LINK.low_power_spindle = st_ff.low_pwr;
    assign LINK.spindle_pwm_drive_select = 1'b0;
    assign LINK.ext_pwm_select = st_ff.ext_pwm;
    assign LINK.freq_loop_disable = (st_ff.hs == H_ANG);
    assign LINK.spindle_speed_target = st_ff.target;
    assign LINK.status_load = st_ff.load;
    assign LINK.status_shift = st_ff.shift;
    assign PRDATA_O = st_ff.prdata;
    assign PREADY_O = st_ff.pready;
    assign PSLVERR_O = st_ff.pslverr;
endmodule
`default_nettype wire

// ==== rtl/pbs_link_if.sv ====
// Interface: command and serial status link between host and device.
// Assumes both ends share CORE_CLK_I.
`timescale 1ns/1ps
`default_nettype none
interface pbs_link_if;
    import pbs_pkg::*;
    pbs_mode_type mode;
    logic spin_run;
    logic low_power_spindle;
    logic spindle_pwm_drive_select;
    logic ext_pwm_select;
    logic freq_loop_disable;
    logic [7:0] spindle_speed_target;
    logic status_load;
    logic status_shift;
    logic serial_status_out;
    modport host (
        output mode, spin_run, low_power_spindle, spindle_pwm_drive_select, ext_pwm_select,
        output freq_loop_disable, spindle_speed_target, status_load, status_shift,
        input serial_status_out
    );
    modport dev (
        input mode, spin_run, low_power_spindle, spindle_pwm_drive_select, ext_pwm_select,
        input freq_loop_disable, spindle_speed_target, status_load, status_shift,
        output serial_status_out
    );
endinterface
`default_nettype wire

// ==== rtl/pbs_pkg.sv ====
// Package: shared constants and types for playback status link.
// Assumes a 20 MHz core clock on both ends.
package pbs_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int LOCK_SAMPLE_HZ = 460;
    localparam int LOCK_SAMPLE_CYC = CLK_HZ / LOCK_SAMPLE_HZ;
    localparam logic [3:0] LOCK_RUN = 4'h8;
    localparam int XTAL_DIV = 128;
    localparam int STAT_BITS = 32;
    localparam logic [5:0] STAT_LAST = 6'h1f;
    // Status word fields
    localparam int ST_JIT_LSB = 0;
    localparam int ST_VEL_LSB = 8;
    localparam int ST_C1_LSB = 16;
    localparam int ST_C2_LSB = 19;
    localparam int ST_FOCUS = 22;
    localparam int ST_GFS = 23;
    localparam int ST_LOCK = 24;
    localparam int ST_WLOCK = 25;
    localparam int ST_PREBOOST = 26;
    // Correction codes
    localparam logic [2:0] C2_FAIL_COPY = 3'h6;
    localparam logic [2:0] C2_FAIL_SET = 3'h7;
    localparam logic [2:0] C2_MAX_FIX = 3'h4;
    // Host register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TARGET = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam logic [7:0] REG_STATWORD = 8'h0c;
    localparam logic [7:0] TARGET_RST = 8'h1f;
    typedef enum logic [1:0] {
        MODE_NARROW,
        MODE_WIDE_LIN,
        MODE_WIDE_ANG
    } pbs_mode_type;
endpackage

// ==== rtl/pbs_status_dev.sv ====
// Device end: playback status flags, lock detectors, velocity count, spindle drive.
// Assumes all inputs synchronous to CORE_CLK_I; host keeps its own sequencing.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Jitter reported as unsigned 8-bit value
// - Frame-sync good when sync meets prediction
// - Lock rises on high, falls after eight lows
// - Wide lock needs eight highs or lows
// - Preboost flag follows disc emphasis
// - C1 result as three-bit code
// - C2 result as three-bit code
// - Wide angular mode: count half-rate speed pulses
// - Reference is crystal divided by 128
// - Wide lock readable on serial status
// - Host starts angular, goes linear on wide lock
// - Host returns angular when lock drops
// - Wide linear low power: no deceleration
// - Host keeps ternary drive in wide modes
// - Angular mode regulates to 8-bit target
// - External PWM: high kick, low brake
// - Angular mode timing follows disc rotation
// - Host disables frequency loop in angular
// - Narrow PLL frequency loop, disable option
// - Channel clock resolves 3T to 11T
// - Three-stage clock chain
// - Narrow mode: conventional, no variable pitch
module pbs_status_dev
    import pbs_pkg::*;
#(
    parameter int SAMPLE_CYC = LOCK_SAMPLE_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    pbs_link_if.dev LINK,
    input wire logic FRAME_SYNC_DET_I,
    input wire logic SYNC_PREDICT_I,
    input wire logic [7:0] JITTER_I,
    input wire logic FOCUS_OK_I,
    input wire logic DISC_DISC_PREBOOST_FLAG_I,
    input wire logic C1_VALID_I,
    input wire logic [1:0] C1_ERRS_I,
    input wire logic C1_PTR_I,
    input wire logic C2_VALID_I,
    input wire logic [2:0] C2_ERRS_I,
    input wire logic C2_FAIL_I,
    input wire logic C2_COPY_C1_I,
    input wire logic CAV_SPEED_CLK_I,
    input wire logic EXT_PWM_I,
    input wire logic SERVO_ACCEL_I,
    input wire logic SERVO_DECEL_I,
    input wire logic [3:0] RUN_LEN_I,
    input wire logic VARI_PITCH_REQ_I,
    output logic LOCK_O,
    output logic WIDE_LOCK_O,
    output logic FRAME_SYNC_GOOD_O,
    output logic PREBOOST_O,
    output logic [7:0] RF_JITTER_O,
    output logic [7:0] VELOCITY_O,
    output logic [2:0] C1_CODE_O,
    output logic [2:0] C2_CODE_O,
    output logic SPIN_ACCEL_O,
    output logic SPIN_DECEL_O,
    output logic FREQ_LOOP_EN_O,
    output logic DISC_CLK_SEL_O,
    output logic VEL_FOLLOW_O,
    output logic RUN_LEN_OK_O,
    output logic VARI_PITCH_O
);
    localparam int TW = $clog2(SAMPLE_CYC + 1);
    localparam int RW = $clog2(XTAL_DIV);
    localparam logic [RW-1:0] REF_HALF_END = RW'(XTAL_DIV / 2 - 1);
    localparam logic [TW-1:0] TICK_END = TW'(SAMPLE_CYC - 1);
    localparam logic [3:0] RUN_MIN = 4'h3;
    localparam logic [3:0] RUN_MAX = 4'hb;

    typedef struct packed {
        logic [TW-1:0] tick_cnt;
        logic [3:0] hi_run;
        logic [3:0] lo_run;
        logic lock;
        logic wlock;
        logic frame_sync_good;
        logic [RW-1:0] ref_cnt;
        logic spd_prev;
        logic spd_half;
        logic [7:0] vel_acc;
        logic [7:0] vel;
        logic [7:0] jit;
        logic focus;
        logic disc_preboost_flag;
        logic [2:0] c1;
        logic [2:0] c2;
        logic [STAT_BITS-1:0] sh;
        logic accel;
        logic decel;
        logic fl_en;
        logic disc_clk;
        logic follow;
        logic rl_ok;
        logic pitch;
    } pbs_dev_state_type;

    pbs_dev_state_type st_ff;
    pbs_dev_state_type nxt_st;
    logic wide;
    logic cav;
    logic ref_high;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        wide = (LINK.mode != MODE_NARROW);
        cav = (LINK.mode == MODE_WIDE_ANG);
        ref_high = (st_ff.ref_cnt <= REF_HALF_END);
        nxt_st.jit = JITTER_I;
        nxt_st.focus = FOCUS_OK_I;
        nxt_st.disc_preboost_flag = DISC_DISC_PREBOOST_FLAG_I;
        // Judged only in the predicted window, so an early sync cannot set it
        if (SYNC_PREDICT_I) begin
            nxt_st.frame_sync_good = FRAME_SYNC_DET_I;
        end else if (FRAME_SYNC_DET_I) begin
            nxt_st.frame_sync_good = 1'b0;
        end
        if (C1_VALID_I) begin
            nxt_st.c1 = {C1_PTR_I | C1_ERRS_I[1], C1_ERRS_I};
        end
        if (C2_VALID_I) begin
            if (C2_FAIL_I) begin
                nxt_st.c2 = C2_COPY_C1_I ? C2_FAIL_COPY : C2_FAIL_SET;
            end else begin
                nxt_st.c2 = (C2_ERRS_I > C2_MAX_FIX) ? C2_MAX_FIX : C2_ERRS_I;
            end
        end
        // Lock sampling
        if (st_ff.tick_cnt == TICK_END) begin
            nxt_st.tick_cnt = '0;
            if (st_ff.frame_sync_good) begin
                nxt_st.lock = 1'b1;
                nxt_st.lo_run = '0;
                if (st_ff.hi_run != LOCK_RUN) begin
                    nxt_st.hi_run = st_ff.hi_run + 4'h1;
                end
                if (st_ff.hi_run == LOCK_RUN - 4'h1) begin
                    nxt_st.wlock = 1'b1;
                end
            end else begin
                nxt_st.hi_run = '0;
                if (st_ff.lo_run != LOCK_RUN) begin
                    nxt_st.lo_run = st_ff.lo_run + 4'h1;
                end
                if (st_ff.lo_run == LOCK_RUN - 4'h1) begin
                    nxt_st.lock = 1'b0;
                    nxt_st.wlock = 1'b0;
                end
            end
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt + TW'(1);
        end
        // Velocity measurement window
        nxt_st.ref_cnt = st_ff.ref_cnt + RW'(1);
        nxt_st.spd_prev = CAV_SPEED_CLK_I;
        if (CAV_SPEED_CLK_I && !st_ff.spd_prev) begin
            nxt_st.spd_half = ~st_ff.spd_half;
            // Every second rise, i.e. the half-rate clock; saturates
            if (ref_high && st_ff.spd_half && st_ff.vel_acc != 8'hff) begin
                nxt_st.vel_acc = st_ff.vel_acc + 8'h01;
            end
        end
        if (st_ff.ref_cnt == REF_HALF_END) begin
            if (cav) begin
                nxt_st.vel = nxt_st.vel_acc;
            end
        end else if (!ref_high) begin
            nxt_st.vel_acc = '0;
        end
        // Spindle drive
        nxt_st.accel = 1'b0;
        nxt_st.decel = 1'b0;
        if (LINK.spin_run) begin
            if (cav && LINK.ext_pwm_select) begin
                nxt_st.accel = EXT_PWM_I;
                nxt_st.decel = !EXT_PWM_I;
            end else if (cav) begin
                nxt_st.accel = st_ff.vel < LINK.spindle_speed_target;
                nxt_st.decel = st_ff.vel > LINK.spindle_speed_target;
            end else begin
                nxt_st.accel = SERVO_ACCEL_I;
                nxt_st.decel = SERVO_DECEL_I;
            end
            // Low power in either wide mode masks deceleration; accel still drives
            if (wide && LINK.low_power_spindle) begin
                nxt_st.decel = 1'b0;
            end
        end
        nxt_st.fl_en = (LINK.mode == MODE_NARROW) && !LINK.freq_loop_disable;
        nxt_st.disc_clk = cav;
        nxt_st.follow = wide;
        nxt_st.rl_ok = (RUN_LEN_I >= RUN_MIN) && (RUN_LEN_I <= RUN_MAX);
        nxt_st.pitch = VARI_PITCH_REQ_I && wide;
        // Serial status
        if (LINK.status_load) begin
            nxt_st.sh = '0;
            nxt_st.sh[ST_JIT_LSB +: 8] = st_ff.jit;
            nxt_st.sh[ST_VEL_LSB +: 8] = st_ff.vel;
            nxt_st.sh[ST_C1_LSB +: 3] = st_ff.c1;
            nxt_st.sh[ST_C2_LSB +: 3] = st_ff.c2;
            nxt_st.sh[ST_FOCUS] = st_ff.focus;
            nxt_st.sh[ST_GFS] = st_ff.frame_sync_good;
            nxt_st.sh[ST_LOCK] = st_ff.lock;
            nxt_st.sh[ST_WLOCK] = st_ff.wlock;
            nxt_st.sh[ST_PREBOOST] = st_ff.disc_preboost_flag;
        end else if (LINK.status_shift) begin
            nxt_st.sh = {st_ff.sh[STAT_BITS-2:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign LINK.serial_status_out = st_ff.sh[STAT_BITS-1];
    assign LOCK_O = st_ff.lock;
    assign WIDE_LOCK_O = st_ff.wlock;
    assign FRAME_SYNC_GOOD_O = st_ff.frame_sync_good;
    assign PREBOOST_O = st_ff.disc_preboost_flag;
    assign RF_JITTER_O = st_ff.jit;
    assign VELOCITY_O = st_ff.vel;
    assign C1_CODE_O = st_ff.c1;
    assign C2_CODE_O = st_ff.c2;
    assign SPIN_ACCEL_O = st_ff.accel;
    assign SPIN_DECEL_O = st_ff.decel;
    assign FREQ_LOOP_EN_O = st_ff.fl_en;
    assign DISC_CLK_SEL_O = st_ff.disc_clk;
    assign VEL_FOLLOW_O = st_ff.follow;
    assign RUN_LEN_OK_O = st_ff.rl_ok;
    assign VARI_PITCH_O = st_ff.pitch;
endmodule
`default_nettype wire

// ==== tb/pbs_link_properties.sv ====
// Checker: timing properties of the status link and the device-end outputs.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pbs_link_properties
    import pbs_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input var pbs_mode_type mode,
    input wire logic spin_run,
    input wire logic low_power_spindle,
    input wire logic spindle_pwm_drive_select,
    input wire logic ext_pwm_select,
    input wire logic freq_loop_disable,
    input wire logic LOCK_O,
    input wire logic WIDE_LOCK_O,
    input wire logic C1_VALID_I,
    input wire logic [1:0] C1_ERRS_I,
    input wire logic C1_PTR_I,
    input wire logic [2:0] C1_CODE_O,
    input wire logic C2_VALID_I,
    input wire logic C2_FAIL_I,
    input wire logic C2_COPY_C1_I,
    input wire logic [2:0] C2_CODE_O,
    input wire logic EXT_PWM_I,
    input wire logic SPIN_ACCEL_O,
    input wire logic SPIN_DECEL_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // Low power left out: it masks decel and is checked apart
    wire logic ang_ext = mode == MODE_WIDE_ANG && ext_pwm_select && spin_run && !low_power_spindle;
    wire logic lin_lp = mode == MODE_WIDE_LIN && low_power_spindle;
    ////////////////////////////////////////////////////////////////////////////
    a_wide_needs_lock: assert property (WIDE_LOCK_O |-> LOCK_O)
        else $error("wide lock high while lock low");
    a_locks_fall_together: assert property ($fell(LOCK_O) |-> !WIDE_LOCK_O)
        else $error("lock fell but wide lock stayed");
    a_c1_code_map: assert property (C1_VALID_I |=> C1_CODE_O == {$past(C1_PTR_I) | $past(C1_ERRS_I[1]), $past(C1_ERRS_I)})
        else $error("c1 code wrong");
    a_c1_no_unused: assert property (C1_CODE_O[2:1] != 2'h1)
        else $error("c1 unused code");
    a_c2_no_unused: assert property (C2_CODE_O != 3'h5)
        else $error("c2 unused code");
    a_c2_fail_code: assert property (C2_VALID_I && C2_FAIL_I |=> C2_CODE_O == ($past(C2_COPY_C1_I) ? C2_FAIL_COPY : C2_FAIL_SET))
        else $error("c2 failure code wrong");
    a_lowpow_no_decel: assert property (lin_lp ##1 lin_lp |-> !SPIN_DECEL_O)
        else $error("decel in low power");
    a_ext_pwm_drive: assert property (ang_ext ##1 ang_ext |-> SPIN_ACCEL_O == $past(EXT_PWM_I) && SPIN_DECEL_O != $past(EXT_PWM_I))
        else $error("external pwm not followed");
    a_ternary_only: assert property (!spindle_pwm_drive_select)
        else $error("pwm drive selected");
    a_fld_in_ang: assert property (mode == MODE_WIDE_ANG ##1 mode == MODE_WIDE_ANG |-> freq_loop_disable)
        else $error("freq loop on in angular mode");
    a_lin_from_ang: assert property ($changed(mode) && mode == MODE_WIDE_LIN |-> $past(mode) == MODE_WIDE_ANG)
        else $error("linear mode not entered from angular");
    c_wide_lock: cover property ($rose(WIDE_LOCK_O));
    c_to_lin: cover property ($changed(mode) && mode == MODE_WIDE_LIN);
    c_ext_kick: cover property (ang_ext && EXT_PWM_I);
endmodule
`default_nettype wire

// ==== tb/playback_status_and_spindle_modes_tb_top.sv ====
// Testbench: host and device ends joined by the link, driven over APB.
// Assumes the short lock sample period below; no partner model is used.
`timescale 1ns/1ps
`default_nettype none
module playback_status_and_spindle_modes_tb_top import pbs_pkg::*; ();
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, det = 0, pred = 0, focus = 0, disc_preboost_flag = 0;
    logic c1v = 0, c1p = 0, c2v = 0, c2f = 0, c2c = 0, spd = 0, spd_en = 0, epwm = 0, rerr;
    logic sacc = 0, sdec = 0, vpr = 1, fle, dcs, vfo, rlo, vpo;
    logic [3:0] rl = 4'h3;
    logic [7:0] paddr = 8'h00, jit = 8'h00;
    logic [31:0] pwdata = 32'h0, rdat, prdata;
    logic [1:0] c1e = 2'h0;
    logic [2:0] c2e = 3'h0, c1o, c2o;
    logic pready, pslverr, lock, wlock, frame_sync_good, pre, acc, dec;
    logic [7:0] rfj, vel;
    int miscompares = 0, checks = 0, cyc = 0;
    // Expected C1 code for errors i[1:0] and pointer i[2]; entry i at bits 3i+2:3i
    localparam logic [23:0] C1_TAB = 24'hfacf88;
    pbs_link_if link_bus();
    // Short sample period keeps eight-sample runs within a few hundred cycles
    pbs_status_dev #(.SAMPLE_CYC(20)) u_pbs_status_dev (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK(link_bus),
        .FRAME_SYNC_DET_I(det), .SYNC_PREDICT_I(pred), .JITTER_I(jit), .FOCUS_OK_I(focus), .DISC_DISC_PREBOOST_FLAG_I(disc_preboost_flag),
        .C1_VALID_I(c1v), .C1_ERRS_I(c1e), .C1_PTR_I(c1p), .C2_VALID_I(c2v), .C2_ERRS_I(c2e), .C2_FAIL_I(c2f),
        .C2_COPY_C1_I(c2c), .CAV_SPEED_CLK_I(spd), .EXT_PWM_I(epwm), .SERVO_ACCEL_I(sacc), .SERVO_DECEL_I(sdec),
        .RUN_LEN_I(rl), .VARI_PITCH_REQ_I(vpr), .LOCK_O(lock), .WIDE_LOCK_O(wlock), .FRAME_SYNC_GOOD_O(frame_sync_good),
        .PREBOOST_O(pre), .RF_JITTER_O(rfj), .VELOCITY_O(vel), .C1_CODE_O(c1o), .C2_CODE_O(c2o),
        .SPIN_ACCEL_O(acc), .SPIN_DECEL_O(dec), .FREQ_LOOP_EN_O(fle), .DISC_CLK_SEL_O(dcs), .VEL_FOLLOW_O(vfo),
        .RUN_LEN_OK_O(rlo), .VARI_PITCH_O(vpo));
    pbs_host_ctl u_pbs_host_ctl (.CORE_CLK_I(clk), .SYS_RST_I(rst), .LINK(link_bus), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr));
    pbs_link_properties u_props (.CORE_CLK_I(clk), .SYS_RST_I(rst), .mode(link_bus.mode),
        .spin_run(link_bus.spin_run), .low_power_spindle(link_bus.low_power_spindle),
        .spindle_pwm_drive_select(link_bus.spindle_pwm_drive_select), .ext_pwm_select(link_bus.ext_pwm_select),
        .freq_loop_disable(link_bus.freq_loop_disable), .LOCK_O(lock), .WIDE_LOCK_O(wlock), .C1_VALID_I(c1v),
        .C1_ERRS_I(c1e), .C1_PTR_I(c1p), .C1_CODE_O(c1o), .C2_VALID_I(c2v), .C2_FAIL_I(c2f),
        .C2_COPY_C1_I(c2c), .C2_CODE_O(c2o), .EXT_PWM_I(epwm), .SPIN_ACCEL_O(acc), .SPIN_DECEL_O(dec));
    ////////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    always @(posedge clk) if (spd_en) spd <= ~spd;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Held until pready is seen high at an edge; released right after that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_state(input logic [1:0] exp);
        int n;
        n = 0;
        do begin
            apb(1'b0, REG_STATE, 32'h0);
            n++;
        end while (rdat[1:0] !== exp && n < 200);
        chk(rdat[1:0], exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_regs();
        chk({lock, wlock, acc, dec}, 4'h0);
        apb(1'b0, REG_TARGET, 32'h0);
        chk(rdat, {24'h0, TARGET_RST});
        apb(1'b1, REG_STATE, 32'h2);
        chk(rerr, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        chk(rerr, 1'b1);
        apb(1'b0, REG_STATE, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task automatic t_narrow();
        chk({fle, dcs, vfo}, 3'h4);
        chk(vpo, 1'b0);
        chk(rlo, 1'b1);
        rl <= 4'h2;
        tick(2);
        chk(rlo, 1'b0);
        rl <= 4'hb;
        tick(2);
        chk(rlo, 1'b1);
        rl <= 4'hc;
        tick(2);
        chk(rlo, 1'b0);
    endtask
    task automatic t_codes();
        for (int i = 0; i < 8; i++) begin
            c1v <= 1'b1;
            c1p <= i[2];
            c1e <= i[1:0];
            c2v <= 1'b1;
            c2e <= (i < 5) ? i[2:0] : 3'h0;
            c2f <= i > 4;
            c2c <= i == 5;
            tick(2);
            chk(c1o, C1_TAB[i*3 +: 3]);
            chk(c2o, (i < 5) ? i[2:0] : ((i == 5) ? 3'h6 : 3'h7));
        end
        c1v <= 1'b0;
        c2v <= 1'b0;
    endtask
    task automatic t_status_word();
        jit <= 8'ha5;
        disc_preboost_flag <= 1'b1;
        focus <= 1'b1;
        tick(3);
        chk({pre, rfj}, 9'h1a5);
        tick(150);
        apb(1'b0, REG_STATWORD, 32'h0);
        chk(rdat[7:0], 8'ha5);
        chk({rdat[ST_PREBOOST], rdat[ST_FOCUS]}, 2'h3);
        disc_preboost_flag <= 1'b0;
        tick(3);
        chk(pre, 1'b0);
    endtask
    task automatic t_lock_seq();
        apb(1'b1, REG_CTRL, 32'h1);
        wait_state(2'h1);
        chk(link_bus.freq_loop_disable, 1'b1);
        chk(dcs, 1'b1);
        chk(vfo, 1'b1);
        chk(fle, 1'b0);
        det <= 1'b1;
        pred <= 1'b1;
        tick(3);
        chk(frame_sync_good, 1'b1);
        tick(30);
        chk({lock, wlock}, 2'h2);
        tick(180);
        chk(wlock, 1'b1);
        wait_state(2'h2);
        apb(1'b0, REG_STATWORD, 32'h0);
        chk(rdat[ST_WLOCK], 1'b1);
        sacc <= 1'b1;
        sdec <= 1'b1;
        tick(3);
        chk({acc, dec}, 2'h3);
        apb(1'b1, REG_CTRL, 32'h3);
        tick(3);
        chk({acc, dec}, 2'h2);
        apb(1'b1, REG_CTRL, 32'h1);
        sacc <= 1'b0;
        sdec <= 1'b0;
        det <= 1'b0;
        tick(30);
        chk({lock, wlock}, 2'h3);
        tick(180);
        chk({lock, wlock}, 2'h0);
        wait_state(2'h1);
    endtask
    task automatic t_velocity_pwm();
        spd_en <= 1'b1;
        tick(300);
        // Half-rate count of a clock toggling every cycle; edge phase gives one count of slack
        chk(vel inside {8'h0f, 8'h10, 8'h11}, 1'b1);
        chk({acc, dec}, 2'h2);
        apb(1'b1, REG_TARGET, 32'h05);
        tick(4);
        chk({acc, dec}, 2'h1);
        spd_en <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h5);
        epwm <= 1'b1;
        tick(4);
        chk({acc, dec}, 2'h2);
        epwm <= 1'b0;
        tick(4);
        chk({acc, dec}, 2'h1);
        apb(1'b1, REG_CTRL, 32'h7);
        tick(4);
        chk({acc, dec}, 2'h0);
        apb(1'b1, REG_CTRL, 32'h0);
        wait_state(2'h0);
    endtask
    initial begin
        tick(3);
        rst <= 1'b0;
        tick(1);
        t_reset_regs();
        t_narrow();
        t_codes();
        t_status_word();
        t_lock_seq();
        t_velocity_pwm();
        stop_test();
    end
endmodule
`default_nettype wire
